// >>> logic/psps_power_ctrl.sv
// Power-state control: standby, clock stop, hybrid sleep, deep power down
`timescale 1ns/1ps
`include "psps_cfg.svh"
module psps_power_ctrl
    import psps_pkg::*;
#(
    parameter int unsigned SLEEP_EXIT_CYC = `PSPS_SLEEP_EXIT_CYC,
    parameter int unsigned PD_EXIT_CYC    = `PSPS_PD_EXIT_CYC,
    parameter int unsigned RAMP_CYC       = `PSPS_RAMP_CYC
) (
    // Clock and power-on reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Memory bus pins
    input  wire logic        select_n_i,
    input  wire logic        bus_clk_i,
    input  wire logic        hw_reset_n_i,
    input  wire logic [7:0]  dq_i,
    output logic      [15:0] dq_o,
    output logic             dq_oe_n_o,
    output logic             read_write_strobe_o,
    output logic             read_write_strobe_oe_n_o,
    // Configuration writes from the transaction logic
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_sel_one_i,
    input  wire logic [15:0] cfg_data_i,
    // Read path from the array
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_data_valid_i,
    input  wire logic        read_drive_i,
    input  wire logic        refresh_busy_i,
    // Command/address capture
    output logic      [7:0]  ca_byte_o,
    output logic             ca_byte_valid_o,
    // Power status
    output logic      [15:0] config_reg_zero_o,
    output logic      [15:0] config_reg_one_o,
    output logic [3:0]       power_state_o,
    output logic             refresh_en_o,
    output logic             low_current_o,
    output logic             ready_o
);

    localparam logic [`PSPS_TMR_W-1:0] SLEEP_ENTRY_VAL =
        `PSPS_TMR_W'(`PSPS_SLEEP_ENTRY_CYC);
    localparam logic [`PSPS_TMR_W-1:0] PD_ENTRY_VAL =
        `PSPS_TMR_W'(`PSPS_PD_ENTRY_CYC);
    localparam logic [`PSPS_TMR_W-1:0] SLEEP_EXIT_VAL =
        `PSPS_TMR_W'(SLEEP_EXIT_CYC);
    localparam logic [`PSPS_TMR_W-1:0] PD_EXIT_VAL =
        `PSPS_TMR_W'(PD_EXIT_CYC);
    localparam logic [`PSPS_TMR_W-1:0] RAMP_VAL =
        `PSPS_TMR_W'(RAMP_CYC);
    localparam logic [`PSPS_IDLE_W-1:0] STOP_VAL =
        `PSPS_IDLE_W'(`PSPS_STOP_CYC);

    // A transfer is open in these two states only
    function automatic logic in_transfer(input psps_state_t st);
        in_transfer = (st == ST_ACTIVE) || (st == ST_CLK_STOP);
    endfunction : in_transfer

    // Synchronised pins
    logic        cs_n_s;
    logic        ck_s;
    logic        hw_rst_n_s;
    logic [7:0]  dq_s;

    psps_sync #(
        .W       (3),
        .RST_VAL (3'h5)
    ) u_sync_ctl (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({select_n_i, bus_clk_i, hw_reset_n_i}),
        .sync_o    ({cs_n_s, ck_s, hw_rst_n_s})
    );

    // Upper lanes never enter the device here
    psps_sync #(
        .W       (8),
        .RST_VAL (8'h00)
    ) u_sync_dq (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (dq_i),
        .sync_o    (dq_s)
    );

    // State and control
    psps_state_t            state_ff;
    psps_state_t            nxt_state;
    logic                   tmr_load;
    logic [`PSPS_TMR_W-1:0] tmr_val;
    logic                   tmr_done;
    logic                   cfg_default;
    logic                   sleep_clear;
    logic                   rst_event;
    logic [15:0]            cfg_zero_ff;
    logic [15:0]            cfg_one_ff;
    logic                   ck_d_ff;
    logic                   ck_edge;
    logic                   hw_rst_d_ff;
    logic [`PSPS_IDLE_W-1:0] idle_ff;
    logic [2:0]             ca_cnt_ff;
    logic                   in_ca;
    logic                   pd_saw_low_ff;
    logic [15:0]            dq_ff;
    logic                   dq_oe_n_ff;
    logic                   read_write_strobe_ff;
    logic                   read_write_strobe_oe_n_ff;
    logic [7:0]             ca_byte_ff;
    logic                   ca_valid_ff;
    logic                   refresh_ff;
    logic                   low_cur_ff;
    logic                   ready_ff;

    psps_timer #(
        .RST_VAL (RAMP_VAL)
    ) u_timer (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .done_o     (tmr_done)
    );

    assign ck_edge   = ck_s != ck_d_ff;
    assign rst_event = hw_rst_d_ff && !hw_rst_n_s;
    assign in_ca     = in_transfer(state_ff) && !cs_n_s &&
                       (ca_cnt_ff < `PSPS_CA_EDGES);

    always_comb begin
        nxt_state   = state_ff;
        tmr_load    = 1'b0;
        tmr_val     = '0;
        cfg_default = 1'b0;
        sleep_clear = 1'b0;
        case (state_ff)
            ST_POWERUP: begin
                if (tmr_done) begin
                    nxt_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                // Nothing but select and hardware reset is looked at
                if (!cs_n_s) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE, ST_CLK_STOP: begin
                if (cs_n_s) begin
                    if (cfg_one_ff[`PSPS_SLEEP_BIT]) begin
                        nxt_state = ST_SLEEP_ENTRY;
                        tmr_load  = 1'b1;
                        tmr_val   = SLEEP_ENTRY_VAL;
                    end else if (!cfg_zero_ff[`PSPS_PD_BIT]) begin
                        nxt_state = ST_PD_ENTRY;
                        tmr_load  = 1'b1;
                        tmr_val   = PD_ENTRY_VAL;
                    end else begin
                        nxt_state = ST_STANDBY;
                    end
                end else if (state_ff == ST_CLK_STOP) begin
                    if (ck_edge) begin
                        nxt_state = ST_ACTIVE;
                    end
                end else if (idle_ff == STOP_VAL) begin
                    nxt_state = ST_CLK_STOP;
                end
            end
            ST_SLEEP_ENTRY: begin
                if (tmr_done) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!cs_n_s) begin
                    nxt_state   = ST_WAKE;
                    sleep_clear = 1'b1;
                    tmr_load    = 1'b1;
                    tmr_val     = SLEEP_EXIT_VAL;
                end
            end
            ST_PD_ENTRY: begin
                if (tmr_done) begin
                    nxt_state = ST_PD;
                end
            end
            ST_PD: begin
                if (pd_saw_low_ff && cs_n_s) begin
                    nxt_state   = ST_WAKE;
                    cfg_default = 1'b1;
                    tmr_load    = 1'b1;
                    tmr_val     = PD_EXIT_VAL;
                end
            end
            ST_WAKE: begin
                if (tmr_done) begin
                    nxt_state = ST_STANDBY;
                end
            end
            default: begin
                nxt_state = ST_POWERUP;
            end
        endcase
        // Hardware reset overrides whatever the state asked for
        if (rst_event) begin
            case (state_ff)
                ST_SLEEP_ENTRY, ST_SLEEP: begin
                    nxt_state   = ST_WAKE;
                    sleep_clear = 1'b1;
                    cfg_default = 1'b0;
                    tmr_load    = 1'b1;
                    tmr_val     = SLEEP_EXIT_VAL;
                end
                ST_PD_ENTRY, ST_PD: begin
                    nxt_state   = ST_WAKE;
                    sleep_clear = 1'b0;
                    cfg_default = 1'b1;
                    tmr_load    = 1'b1;
                    tmr_val     = PD_EXIT_VAL;
                end
                ST_POWERUP, ST_WAKE: begin
                    nxt_state = state_ff;
                end
                default: begin
                    nxt_state   = ST_STANDBY;
                    cfg_default = 1'b1;
                    tmr_load    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_ff    <= ST_POWERUP;
            hw_rst_d_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            hw_rst_d_ff <= hw_rst_n_s;
        end
    end

    // Sleep keeps both registers; writes are taken in the active state only, so none lands in the clearing cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || cfg_default) begin
            cfg_zero_ff <= `PSPS_CFG_ZERO_RST;
            cfg_one_ff  <= `PSPS_CFG_ONE_RST;
        end else begin
            if (sleep_clear) begin
                cfg_one_ff[`PSPS_SLEEP_BIT] <= 1'b0;
            end
            if (cfg_wr_i && state_ff == ST_ACTIVE) begin
                if (cfg_sel_one_i) begin
                    cfg_one_ff <= cfg_data_i;
                end else begin
                    cfg_zero_ff <= cfg_data_i;
                end
            end
        end
    end

    // Only a clock held low counts toward the stop time
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ck_d_ff <= 1'b0;
            idle_ff <= '0;
        end else begin
            ck_d_ff <= ck_s;
            if (state_ff != ST_ACTIVE || ck_edge || ck_s) begin
                idle_ff <= '0;
            end else if (idle_ff != STOP_VAL) begin
                idle_ff <= idle_ff + `PSPS_IDLE_W'(1);
            end
        end
    end

    // One byte per clock edge; DDR gives two per bus clock
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ca_cnt_ff   <= 3'h0;
            ca_byte_ff  <= 8'h00;
            ca_valid_ff <= 1'b0;
        end else begin
            ca_valid_ff <= 1'b0;
            if (cs_n_s || !in_transfer(state_ff)) begin
                ca_cnt_ff <= 3'h0;
            end else if (in_ca && ck_edge) begin
                ca_cnt_ff   <= ca_cnt_ff + 3'h1;
                ca_byte_ff  <= dq_s;
                ca_valid_ff <= 1'b1;
            end
        end
    end

    // Deep power down waits for a full low-then-high select
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || state_ff != ST_PD) begin
            pd_saw_low_ff <= 1'b0;
        end else if (!cs_n_s) begin
            pd_saw_low_ff <= 1'b1;
        end
    end

    // Bus drivers; clock stop freezes data while still driving it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            dq_ff        <= 16'h0000;
            dq_oe_n_ff   <= 1'b1;
            read_write_strobe_ff      <= 1'b0;
            read_write_strobe_oe_n_ff <= 1'b1;
        end else if (!in_transfer(nxt_state) || cs_n_s) begin
            dq_oe_n_ff   <= 1'b1;
            read_write_strobe_oe_n_ff <= 1'b1;
            read_write_strobe_ff      <= 1'b0;
        end else if (state_ff == ST_CLK_STOP) begin
            dq_oe_n_ff <= dq_oe_n_ff;
        end else if (in_ca) begin
            read_write_strobe_oe_n_ff <= 1'b0;
            read_write_strobe_ff      <= refresh_busy_i;
            dq_oe_n_ff   <= 1'b1;
        end else begin
            dq_oe_n_ff   <= !read_drive_i;
            read_write_strobe_oe_n_ff <= !read_drive_i;
            if (read_drive_i && rd_data_valid_i) begin
                dq_ff   <= rd_data_i;
                read_write_strobe_ff <= !read_write_strobe_ff;
            end
        end
    end

    // Refresh stops at power down entry and after a reset in sleep
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            refresh_ff <= 1'b0;
            low_cur_ff <= 1'b0;
            ready_ff   <= 1'b0;
        end else begin
            if (nxt_state == ST_PD_ENTRY || rst_event) begin
                refresh_ff <= 1'b0;
            end else if (nxt_state == ST_STANDBY) begin
                refresh_ff <= 1'b1;
            end
            low_cur_ff <= (nxt_state == ST_CLK_STOP) ||
                          (nxt_state == ST_SLEEP) || (nxt_state == ST_PD);
            ready_ff   <= nxt_state == ST_STANDBY;
        end
    end

    assign dq_o                     = dq_ff;
    assign dq_oe_n_o                = dq_oe_n_ff;
    assign read_write_strobe_o      = read_write_strobe_ff;
    assign read_write_strobe_oe_n_o = read_write_strobe_oe_n_ff;
    assign ca_byte_o                = ca_byte_ff;
    assign ca_byte_valid_o          = ca_valid_ff;
    assign config_reg_zero_o        = cfg_zero_ff;
    assign config_reg_one_o         = cfg_one_ff;
    assign power_state_o            = state_ff;
    assign refresh_en_o             = refresh_ff;
    assign low_current_o            = low_cur_ff;
    assign ready_o                  = ready_ff;

endmodule : psps_power_ctrl

// >>> shared/psps_cfg.svh
// Constants for the power-state control of the self-refreshing DRAM
// Notes on behaviour
// - Chip select high: interface standby, only select and hardware reset count.
// - Bus clock still for access time plus 30 ns: enter clock stop; the code counts only a bus clock held low.
// - In clock stop, read data stays latched and driven on the data bus.
// - Toggling clock after clock stop resumes the stalled transfer.
// - Upper data lanes are ignored by the device during command/address.
// - Strobe is driven low during command/address when no extra latency.
// - Writing one to the sleep request bit enters hybrid sleep.
// - Reduced power is reached within 3 us of the sleep request.
// - Array and configuration are retained throughout hybrid sleep.
// - Chip select low ends hybrid sleep and clears the sleep request bit.
// - Power-on or hardware reset ends hybrid sleep and stops refresh.
// - Sleep exit needs up to 100 us, then state equals sleep entry.
// - Writing zero to the power down disable bit enters deep power down.
// - Deep power down stops refresh within entry time; array becomes invalid.
// - Chip select low then high ends deep power down.
// - Power-on or hardware reset also ends deep power down.
// - Deep power down exit waits exit or ramp time, then defaults.
`ifndef PSPS_CFG_SVH
`define PSPS_CFG_SVH

`define PSPS_CLK_PERIOD_NS     8
`define PSPS_ACCESS_TIME_NS    40
`define PSPS_STOP_EXTRA_NS     30
`define PSPS_SLEEP_ENTRY_NS    3000
`define PSPS_SLEEP_EXIT_NS     100000
`define PSPS_PD_ENTRY_NS       10000
`define PSPS_PD_EXIT_NS        150000
`define PSPS_SUPPLY_RAMP_NS    150000

// Least time rounds up, longest time rounds down
`define PSPS_STOP_CYC  ((`PSPS_ACCESS_TIME_NS + `PSPS_STOP_EXTRA_NS + \
                         `PSPS_CLK_PERIOD_NS - 1) / `PSPS_CLK_PERIOD_NS)
`define PSPS_SLEEP_ENTRY_CYC (`PSPS_SLEEP_ENTRY_NS / `PSPS_CLK_PERIOD_NS)
`define PSPS_PD_ENTRY_CYC    (`PSPS_PD_ENTRY_NS / `PSPS_CLK_PERIOD_NS)
`define PSPS_SLEEP_EXIT_CYC  (`PSPS_SLEEP_EXIT_NS / `PSPS_CLK_PERIOD_NS)
`define PSPS_PD_EXIT_CYC     (`PSPS_PD_EXIT_NS / `PSPS_CLK_PERIOD_NS)
`define PSPS_RAMP_CYC        (`PSPS_SUPPLY_RAMP_NS / `PSPS_CLK_PERIOD_NS)

`define PSPS_TMR_W       20
`define PSPS_IDLE_W      8
`define PSPS_CA_EDGES    3'h6
`define PSPS_SLEEP_BIT   5
`define PSPS_PD_BIT      15
`define PSPS_CFG_ZERO_RST 16'h8000
`define PSPS_CFG_ONE_RST  16'h0000

`endif

// >>> shared/psps_pkg.sv
// Types for the power-state control block
package psps_pkg;

    // Gray codes along power-up, standby, transfer, sleep and power down
    typedef enum logic [3:0] {
        ST_POWERUP     = 4'h0,
        ST_STANDBY     = 4'h1,
        ST_ACTIVE      = 4'h3,
        ST_CLK_STOP    = 4'h2,
        ST_SLEEP_ENTRY = 4'h6,
        ST_SLEEP       = 4'h7,
        ST_PD_ENTRY    = 4'h5,
        ST_PD          = 4'h4,
        ST_WAKE        = 4'hc
    } psps_state_t;

endpackage : psps_pkg

// >>> logic/psps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psps_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : psps_sync

// >>> logic/psps_timer.sv
// Down counter for entry and exit waits
`timescale 1ns/1ps
`include "psps_cfg.svh"
module psps_timer #(
    parameter logic [`PSPS_TMR_W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    // Load and expiry
    input  wire logic                   load_i,
    input  wire logic [`PSPS_TMR_W-1:0] load_val_i,
    output logic                        done_o
);

    logic [`PSPS_TMR_W-1:0] cnt_ff;

    // Reset starts the supply ramp wait straight away
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_ff <= RST_VAL;
        end else if (load_i) begin
            cnt_ff <= load_val_i;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - `PSPS_TMR_W'(1);
        end
    end

    assign done_o = (cnt_ff == '0) && !load_i;

endmodule : psps_timer

// >>> sim/psps_power_ctrl_sva.sv
// Checker for the power-state control block, bound to its ports
`timescale 1ns/1ps
module psps_power_ctrl_sva
    import psps_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Watched pins and status
    input  wire logic        select_n_i,
    input  wire logic        bus_clk_i,
    input  wire logic        refresh_busy_i,
    input  wire logic [15:0] dq_o,
    input  wire logic        dq_oe_n_o,
    input  wire logic        read_write_strobe_o,
    input  wire logic        read_write_strobe_oe_n_o,
    input  wire logic        ca_byte_valid_o,
    input  wire logic [15:0] config_reg_one_o,
    input  wire logic [3:0]  power_state_o,
    input  wire logic        refresh_en_o,
    input  wire logic        low_current_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Pin-side count of a low bus clock inside a frame; the design lags it
    logic [4:0] low_cnt_ff;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || bus_clk_i || select_n_i) begin
            low_cnt_ff <= 5'h00;
        end else if (low_cnt_ff != 5'h1f) begin
            low_cnt_ff <= low_cnt_ff + 5'h01;
        end
    end

    sequence s_sleep_start;
        $rose(power_state_o == ST_SLEEP_ENTRY);
    endsequence
    sequence s_sleep_reached;
        (power_state_o == ST_SLEEP) && low_current_o;
    endsequence

    property p_standby_quiet;
        power_state_o == ST_STANDBY && $past(power_state_o) == ST_STANDBY
            |-> dq_oe_n_o && read_write_strobe_oe_n_o && !ca_byte_valid_o;
    endproperty
    property p_stop_late;
        low_cnt_ff == 5'h12 |-> power_state_o != ST_ACTIVE;
    endproperty
    property p_stop_early;
        $rose(power_state_o == ST_CLK_STOP) |-> low_cnt_ff >= 5'h09;
    endproperty
    property p_stop_hold;
        power_state_o == ST_CLK_STOP && $past(power_state_o) == ST_CLK_STOP
            |-> $stable(dq_o) && $stable(dq_oe_n_o) && low_current_o;
    endproperty
    property p_stop_resume;
        power_state_o == ST_CLK_STOP && $rose(bus_clk_i)
            |-> ##[1:4] power_state_o == ST_ACTIVE;
    endproperty
    property p_ca_strobe;
        ca_byte_valid_o |-> !read_write_strobe_oe_n_o
            && read_write_strobe_o == refresh_busy_i;
    endproperty
    property p_sleep_entry;
        s_sleep_start |-> ##[1:375] s_sleep_reached;
    endproperty
    property p_sleep_keep;
        power_state_o == ST_SLEEP |-> $stable(config_reg_one_o);
    endproperty
    property p_sleep_wake;
        power_state_o == ST_WAKE && $past(power_state_o) == ST_SLEEP
            |-> !config_reg_one_o[5];
    endproperty
    property p_pd_refresh;
        power_state_o inside {ST_PD_ENTRY, ST_PD} |-> !refresh_en_o;
    endproperty

    a_standby_quiet: assert property (p_standby_quiet)
        else $error("outputs active in standby");
    a_stop_late: assert property (p_stop_late)
        else $error("clock stop not entered");
    a_stop_early: assert property (p_stop_early)
        else $error("clock stop entered too soon");
    a_stop_hold: assert property (p_stop_hold)
        else $error("read data not held in clock stop");
    a_stop_resume: assert property (p_stop_resume)
        else $error("transfer not resumed");
    a_ca_strobe: assert property (p_ca_strobe)
        else $error("strobe wrong during command phase");
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not reached in time");
    a_sleep_keep: assert property (p_sleep_keep)
        else $error("config changed in sleep");
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep request bit not cleared");
    a_pd_refresh: assert property (p_pd_refresh)
        else $error("refresh running in power down");
endmodule : psps_power_ctrl_sva

bind psps_power_ctrl psps_power_ctrl_sva chk_u (.*);

// >>> sim/psps_host_model.sv
// Host memory controller model: select, bus clock and low data lanes
`timescale 1ns/1ps
module psps_host_model (
    // Clock
    input  wire logic       clk_i,
    // Pins toward the device
    output logic            select_n_o,
    output logic            bus_clk_o,
    output logic [7:0]      dq_o
);
    // Bus clock idles low; upper lanes are not modelled
    initial begin
        select_n_o = 1'b1;
        bus_clk_o  = 1'b0;
        dq_o       = 8'h00;
    end

    task automatic frame_begin(input int unsigned n);
        @(posedge clk_i);
        select_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : frame_begin

    // One bus clock edge, 40 ns per half period; lanes settle first
    task automatic send_byte(input logic [7:0] b);
        dq_o <= b;
        repeat (2) @(posedge clk_i);
        bus_clk_o <= ~bus_clk_o;
        repeat (3) @(posedge clk_i);
    endtask : send_byte

    // Pauses only with the clock low, never during a register access
    task automatic pause(input int unsigned n);
        repeat (n) @(posedge clk_i);
    endtask : pause

    // Released lanes show the inverse, so a stale value cannot pass
    task automatic frame_end();
        @(posedge clk_i);
        select_n_o <= 1'b1;
        dq_o       <= ~dq_o;
    endtask : frame_end
endmodule : psps_host_model

// >>> sim/test_psps_power_ctrl.sv
// Self-checking bench for the power-state control block
`timescale 1ns/1ps
module test_psps_power_ctrl
    import psps_pkg::*;
;
    localparam logic [7:0] CA_TAB [6] = '{8'ha0, 8'h12, 8'h34, 8'h56,
                                          8'h00, 8'h07};
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        select_n_i, bus_clk_i, hw_reset_n_i;
    logic [7:0]  dq_i, ca_byte_o;
    logic [15:0] dq_o, cfg_data_i, rd_data_i;
    logic        dq_oe_n_o, read_write_strobe_o, read_write_strobe_oe_n_o;
    logic        cfg_wr_i, cfg_sel_one_i = 1'b0;
    logic        rd_data_valid_i = 1'b0, read_drive_i = 1'b0;
    logic        refresh_busy_i = 1'b0, ca_byte_valid_o;
    logic [15:0] config_reg_zero_o, config_reg_one_o;
    logic [3:0]  power_state_o;
    logic        refresh_en_o, low_current_o, ready_o;
    int          err_count = 0;
    int          n_compared = 0;
    logic [7:0]  ca_q [$];

    always #4 clk_i = ~clk_i;

    psps_host_model host_u (.clk_i(clk_i), .select_n_o(select_n_i),
        .bus_clk_o(bus_clk_i), .dq_o(dq_i));

    // Short exit and ramp counts keep the run brief
    psps_power_ctrl #(.SLEEP_EXIT_CYC(20), .PD_EXIT_CYC(20), .RAMP_CYC(20))
    dut_u (.*);

    always @(posedge clk_i) begin
        if (ca_byte_valid_o === 1'b1) begin
            ca_q.push_back(ca_byte_o);
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Bounded wait on the state code, judged on the falling edge
    task automatic wait_state(input logic [3:0] code, input int unsigned lim);
        int unsigned i;
        i = 0;
        @(negedge clk_i);
        while (power_state_o !== code && i < lim) begin
            @(negedge clk_i);
            i++;
        end
        check({12'h000, power_state_o}, {12'h000, code});
    endtask : wait_state

    task automatic ca_frame();
        host_u.frame_begin(6);
        foreach (CA_TAB[i]) begin
            host_u.send_byte(CA_TAB[i]);
        end
    endtask : ca_frame

    task automatic cfg_write(input logic sel, input logic [15:0] data);
        @(posedge clk_i);
        cfg_wr_i      <= 1'b1;
        cfg_sel_one_i <= sel;
        cfg_data_i    <= data;
        @(posedge clk_i);
        cfg_wr_i      <= 1'b0;
    endtask : cfg_write

    task automatic t_power_on();
        wait_state(ST_STANDBY, 60);
        check({15'h0000, ready_o}, 16'h0001);
        check(config_reg_zero_o, 16'h8000);
        check(config_reg_one_o, 16'h0000);
    endtask : t_power_on

    // Extra latency asked for, so the strobe must be high in the CA phase
    task automatic t_command_capture();
        @(posedge clk_i);
        refresh_busy_i <= 1'b1;
        ca_q.delete();
        ca_frame();
        host_u.frame_end();
        wait_state(ST_STANDBY, 10);
        check(16'(ca_q.size()), 16'h0006);
        foreach (CA_TAB[i]) begin
            check({8'h00, ca_q[i]}, {8'h00, CA_TAB[i]});
        end
        check({15'h0000, dq_oe_n_o}, 16'h0001);
        refresh_busy_i <= 1'b0;
    endtask : t_command_capture

    task automatic t_clock_stop();
        ca_frame();
        read_drive_i    <= 1'b1;
        rd_data_i       <= 16'h5ac3;
        rd_data_valid_i <= 1'b1;
        @(posedge clk_i);
        rd_data_valid_i <= 1'b0;
        rd_data_i       <= 16'h0000;
        host_u.pause(20);
        wait_state(ST_CLK_STOP, 4);
        check({15'h0000, low_current_o}, 16'h0001);
        check(dq_o, 16'h5ac3);
        check({15'h0000, dq_oe_n_o}, 16'h0000);
        host_u.send_byte(8'h00);
        wait_state(ST_ACTIVE, 6);
        read_drive_i <= 1'b0;
        host_u.frame_end();
        wait_state(ST_STANDBY, 10);
    endtask : t_clock_stop

    task automatic t_sleep();
        ca_frame();
        cfg_write(1'b1, 16'h0025);
        host_u.frame_end();
        wait_state(ST_SLEEP, 400);
        check(config_reg_one_o, 16'h0025);
        host_u.frame_begin(10);
        host_u.frame_end();
        wait_state(ST_WAKE, 10);
        check(config_reg_one_o, 16'h0005);
        wait_state(ST_STANDBY, 40);
        check(config_reg_zero_o, 16'h8000);
    endtask : t_sleep

    task automatic t_power_down(input bit by_reset);
        ca_frame();
        cfg_write(1'b0, 16'h0f1f);
        host_u.frame_end();
        wait_state(ST_PD_ENTRY, 10);
        check({15'h0000, refresh_en_o}, 16'h0000);
        wait_state(ST_PD, 1300);
        if (by_reset) begin
            hw_reset_n_i <= 1'b0;
            repeat (6) @(posedge clk_i);
            hw_reset_n_i <= 1'b1;
        end else begin
            host_u.frame_begin(10);
            host_u.frame_end();
        end
        wait_state(ST_STANDBY, 60);
        check(config_reg_zero_o, 16'h8000);
        check(config_reg_one_o, 16'h0000);
    endtask : t_power_down

    initial begin
        #200000;
        err_count++;
        complete_run();
    end

    initial begin
        {cfg_wr_i, hw_reset_n_i} <= 2'b01;
        {cfg_data_i, rd_data_i} <= 32'h0;
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_power_on();
        t_command_capture();
        t_clock_stop();
        t_sleep();
        t_power_down(1'b0);
        t_power_down(1'b1);
        complete_run();
    end
endmodule : test_psps_power_ctrl
